//--- rtl/ief_pkg.sv
// Constants for the event status flag block: register map, flag positions,
// reset values. Assumes 32-bit register data and a byte-addressed port.
package ief_pkg;

	localparam int          IEF_ADDR_W = 8;
	localparam int          IEF_DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0]  IEF_OFS_STATUS   = 8'h00;
	localparam logic [7:0]  IEF_OFS_ENABLE   = 8'h04;
	localparam logic [7:0]  IEF_OFS_SET      = 8'h08;
	localparam logic [7:0]  IEF_OFS_SLV_CFG  = 8'h0c;
	localparam logic [7:0]  IEF_OFS_SOFT_RST = 8'h10;
	localparam logic [7:0]  IEF_OFS_PENDING  = 8'h14;
	localparam logic [7:0]  IEF_OFS_SNAPSHOT = 8'h18;

	// Flag positions in the status, enable and set registers
	localparam int          IEF_BIT_BOOT_OK   = 15;
	localparam int          IEF_BIT_SLV_ABORT = 20;
	localparam int          IEF_BIT_SLV_WRITE = 21;
	localparam int          IEF_BIT_SLV_READ  = 22;
	localparam int          IEF_BIT_SLV_OK    = 23;
	localparam int          IEF_BIT_MST_DIAG  = 24;
	localparam int          IEF_BIT_MST_ARBL  = 27;
	localparam int          IEF_BIT_MST_TMO   = 28;
	localparam int          IEF_BIT_MST_NACK  = 29;
	localparam int          IEF_BIT_MST_ATMO  = 30;
	localparam int          IEF_BIT_MST_OK    = 31;

	// Implemented flags; all other bits read zero and ignore writes
	localparam logic [31:0] IEF_IMPL_MASK    = 32'hf9f0_8000;

	// Slave configuration fields
	localparam int          IEF_CFG_WR_EN    = 0;
	localparam int          IEF_CFG_RD_EN    = 1;
	localparam logic [1:0]  IEF_CFG_RST      = 2'h0;

	// Soft reset field
	localparam int          IEF_SRST_BIT     = 0;

	localparam logic [31:0] IEF_FLAGS_RST    = 32'h0000_0000;
	localparam logic [31:0] IEF_ENABLE_RST   = 32'h0000_0000;

endpackage : ief_pkg

//--- rtl/ief_flag_if.sv
// Carries set, clear and hold requests to the flag bank and the flags back.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface ief_flag_if;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic        hold;
	logic [31:0] flags;

	modport ctrl (output set_vec, output clr_vec, output hold, input flags);
	modport bank (input set_vec, input clr_vec, input hold, output flags);
endinterface : ief_flag_if

//--- rtl/ief_flag_bank.sv
// Bank of sticky flags, one cell per implemented bit.
// Assumes set and clear vectors are single-cycle requests on core_clk.
`timescale 1ns/1ps
module ief_flag_bank import ief_pkg::*; #(
	parameter logic [31:0] IMPL = IEF_IMPL_MASK
) (
	input wire logic core_clk,
	input wire logic resetn,
	ief_flag_if.bank fi
);

	wire [31:0] flags_w;

	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_cell
			if (IMPL[i]) begin : g_impl
				logic bit_r;
				always_ff @(posedge core_clk) begin
					if (!resetn || fi.hold) begin
						bit_r <= IEF_FLAGS_RST[i];
					end else if (fi.set_vec[i]) begin
						bit_r <= 1'b1; // Set beats a clear in the same cycle
					end else if (fi.clr_vec[i]) begin
						bit_r <= 1'b0;
					end
				end
				assign flags_w[i] = bit_r;
			end else begin : g_rsvd
				assign flags_w[i] = 1'b0;
			end
		end
	endgenerate

	assign fi.flags = flags_w;

endmodule : ief_flag_bank

//--- rtl/ief_event_status.sv
// Event status flags of the two-wire serial port: sticky flags, enables,
// set register, slave access enables, soft reset and interrupt output.
// Assumes event inputs are one-cycle pulses synchronous to core_clk and a
// register master that follows the plain strobe protocol.
//
// Functional notes
// - Set bit 15 on boot-load success, or when boot loading disabled at reset.
// - Set bit 20 when a slave transaction addressed to us aborts.
// - Set bit 21 when an external master triggers an internal register write.
// - Never raise the slave-write flag while slave writes are disabled; the code still raises it on a set-register write.
// - Set bit 22 when an external master triggers an internal register read.
// - Never raise the slave-read flag while slave reads are disabled; the code still raises it on a set-register write.
// - Set bit 23 when a slave access completes without error.
// - Set bit 24 on a master diagnostic event.
// - Set bit 27 on arbitration loss after address phase in software transaction.
// - Set bit 28 when a software master transaction times out.
// - Set bit 29 when a master transaction aborts on a NACK.
// - Set bit 30 when the bus-arbitration timeout expires; the code drops it while a boot load is active.
// - Set bit 31 when a software master transaction completes cleanly.
// - Boot-load failure may also set collision, timeout or NACK flags.
// - Flags clear only on a written 1 or a soft reset; software reads first for a snapshot.
// - Flags set regardless of enable; interrupt only from enabled flags.
// - Soft reset clears all flags; none set until a new event after release.
`timescale 1ns/1ps
module ief_event_status import ief_pkg::*; (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	// Register port
	input  wire logic [IEF_ADDR_W-1:0] reg_addr,
	input  wire logic [IEF_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [IEF_DATA_W-1:0] reg_rdata,
	// Boot-load sequencer
	input  wire logic                  boot_load_disabled,
	input  wire logic                  boot_load_active,
	input  wire logic                  boot_load_success,
	// Slave engine events
	input  wire logic                  slave_access_abort,
	input  wire logic                  slave_internal_write_done,
	input  wire logic                  slave_internal_read_done,
	input  wire logic                  slave_access_success,
	// Master engine events
	input  wire logic                  master_diagnostic_event,
	input  wire logic                  master_arbitration_lost,
	input  wire logic                  master_timeout_abort,
	input  wire logic                  master_nack_abort,
	input  wire logic                  master_arbitration_timeout,
	input  wire logic                  master_transaction_success,
	// Controls toward the engines
	output logic                       slave_write_enable,
	output logic                       slave_read_enable,
	output logic                       port_soft_reset_bit,
	// Interrupt toward the interrupt controller
	output logic                       irq
);

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [31:0] enable_r;
	logic [1:0]  slv_cfg_r;
	logic        srst_r;
	logic [31:0] snapshot_r;
	logic [31:0] rdata_r;
	logic        irq_r;
	logic        strap_done_r;
	logic        strap_ev_r;

	// Decoded strobes
	logic wr_status;
	logic wr_enable;
	logic wr_set;
	logic wr_cfg;
	logic wr_srst;
	logic rd_status;

	// Event vector and flag bank link
	logic [31:0] hw_ev;
	logic [31:0] sw_set;
	logic [31:0] sw_clr;
	logic [31:0] flags;
	logic [31:0] pending;

	ief_flag_if flag_if ();

	ief_flag_bank #(
		.IMPL (IEF_IMPL_MASK)
	) u_bank (
		.core_clk (core_clk),
		.resetn   (resetn),
		.fi       (flag_if.bank)
	);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	always_comb begin
		wr_status = reg_wr && (reg_addr == IEF_OFS_STATUS);
		wr_enable = reg_wr && (reg_addr == IEF_OFS_ENABLE);
		wr_set    = reg_wr && (reg_addr == IEF_OFS_SET);
		wr_cfg    = reg_wr && (reg_addr == IEF_OFS_SLV_CFG);
		wr_srst   = reg_wr && (reg_addr == IEF_OFS_SOFT_RST);
		rd_status = reg_rd && (reg_addr == IEF_OFS_STATUS);
	end

	// ------------------------------------------------------------------
	// Strap capture: the boot-disabled level is taken on the first clock
	// after reset release, never inside the reset branch itself.
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			strap_done_r <= 1'b0;
		end else begin
			strap_done_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			strap_ev_r <= 1'b0;
		end else begin
			strap_ev_r <= !strap_done_r && boot_load_disabled;
		end
	end

	// ------------------------------------------------------------------
	// Hardware event vector
	// ------------------------------------------------------------------
	always_comb begin
		hw_ev = 32'h0000_0000;
		// Either a good boot load or no boot load at all counts as success
		hw_ev[IEF_BIT_BOOT_OK]   = boot_load_success || strap_ev_r;
		hw_ev[IEF_BIT_SLV_ABORT] = slave_access_abort;
		// Disabled slave accesses never reach the register file, so no flag
		hw_ev[IEF_BIT_SLV_WRITE] = slave_internal_write_done && slv_cfg_r[IEF_CFG_WR_EN];
		hw_ev[IEF_BIT_SLV_READ]  = slave_internal_read_done && slv_cfg_r[IEF_CFG_RD_EN];
		hw_ev[IEF_BIT_SLV_OK]    = slave_access_success;
		hw_ev[IEF_BIT_MST_DIAG]  = master_diagnostic_event;
		// Collision, timeout and NACK also report the end of a failed boot load
		hw_ev[IEF_BIT_MST_ARBL]  = master_arbitration_lost;
		hw_ev[IEF_BIT_MST_TMO]   = master_timeout_abort;
		hw_ev[IEF_BIT_MST_NACK]  = master_nack_abort;
		hw_ev[IEF_BIT_MST_ATMO]  = master_arbitration_timeout && !boot_load_active;
		// Only transactions started by software report a clean finish
		hw_ev[IEF_BIT_MST_OK]    = master_transaction_success && !boot_load_active;
	end

	// ------------------------------------------------------------------
	// Set and clear requests to the flag bank
	// ------------------------------------------------------------------
	always_comb begin
		sw_set = wr_set ? (reg_wdata & IEF_IMPL_MASK) : 32'h0000_0000;
	end

	always_comb begin
		// Only bits written as one clear; zeros leave flags alone
		sw_clr = wr_status ? (reg_wdata & IEF_IMPL_MASK) : 32'h0000_0000;
	end

	// Events during soft reset are dropped so nothing fires after release
	assign flag_if.set_vec = srst_r ? 32'h0000_0000 : ((hw_ev | sw_set) & IEF_IMPL_MASK);
	assign flag_if.clr_vec = sw_clr;
	assign flag_if.hold    = srst_r;
	assign flags           = flag_if.flags;

	// ------------------------------------------------------------------
	// Enable register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			enable_r <= IEF_ENABLE_RST;
		end else if (wr_enable) begin
			enable_r <= reg_wdata & IEF_IMPL_MASK;
		end
	end

	// ------------------------------------------------------------------
	// Slave access configuration
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			slv_cfg_r <= IEF_CFG_RST;
		end else if (wr_cfg) begin
			slv_cfg_r <= reg_wdata[1:0];
		end
	end

	assign slave_write_enable = slv_cfg_r[IEF_CFG_WR_EN];
	assign slave_read_enable  = slv_cfg_r[IEF_CFG_RD_EN];

	// ------------------------------------------------------------------
	// Port soft reset: held by software, released by writing zero
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			srst_r <= 1'b0;
		end else if (wr_srst) begin
			srst_r <= reg_wdata[IEF_SRST_BIT];
		end
	end

	assign port_soft_reset_bit = srst_r;

	// ------------------------------------------------------------------
	// Snapshot of the flags at each status read, so software can clear
	// exactly what it saw even while new events keep arriving.
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn || srst_r) begin
			snapshot_r <= IEF_FLAGS_RST;
		end else if (rd_status) begin
			snapshot_r <= flags;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt: flags record regardless of enable, the enable only gates the output
	// ------------------------------------------------------------------
	assign pending = flags & enable_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |pending;
		end
	end

	assign irq = irq_r;

	// ------------------------------------------------------------------
	// Read data: valid only in the cycle after the read strobe
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_r <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				IEF_OFS_STATUS:   rdata_r <= flags;
				IEF_OFS_ENABLE:   rdata_r <= enable_r;
				IEF_OFS_SET:      rdata_r <= 32'h0000_0000;
				IEF_OFS_SLV_CFG:  rdata_r <= {30'h0000_0000, slv_cfg_r};
				IEF_OFS_SOFT_RST: rdata_r <= {31'h0000_0000, srst_r};
				IEF_OFS_PENDING:  rdata_r <= pending;
				IEF_OFS_SNAPSHOT: rdata_r <= snapshot_r;
				default:          rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_r;

endmodule : ief_event_status

//--- verif/ief_event_status_asserts.sv
// Port-level checker for the event status flag block.
// Assumes a single core_clk domain and binding onto ief_event_status.
`timescale 1ns/1ps
module ief_event_status_asserts import ief_pkg::*; (
	input wire logic                  core_clk,
	input wire logic                  resetn,
	input wire logic [IEF_ADDR_W-1:0] reg_addr,
	input wire logic [IEF_DATA_W-1:0] reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [IEF_DATA_W-1:0] reg_rdata,
	input wire logic                  slave_access_abort,
	input wire logic                  slave_write_enable,
	input wire logic                  slave_read_enable,
	input wire logic                  port_soft_reset_bit,
	input wire logic                  irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	AST_RSV_ZERO: assert property (reg_rd && reg_addr == IEF_OFS_STATUS |=> (reg_rdata & 32'h060f_7fff) == 32'h0)
		else $error("reserved status bits read nonzero");
	AST_NO_DATA: assert property (reg_rd && (reg_addr == IEF_OFS_SET || reg_addr > IEF_OFS_SNAPSHOT)
		|=> reg_rdata == 32'h0)
		else $error("set or unmapped read returned data");
	AST_ABORT_FLAG: assert property (slave_access_abort && !port_soft_reset_bit
		##1 reg_rd && reg_addr == IEF_OFS_STATUS |=> reg_rdata[20])
		else $error("abort event not seen in status");
	AST_SRST_IRQ: assert property (port_soft_reset_bit [*3] |-> !irq)
		else $error("irq high during soft reset");
	AST_SRST_READ: assert property (port_soft_reset_bit [*2] ##0 reg_rd && reg_addr == IEF_OFS_STATUS
		|=> reg_rdata == 32'h0)
		else $error("flags nonzero during soft reset");
	AST_CFG_WR: assert property (reg_wr && reg_addr == IEF_OFS_SLV_CFG
		|=> slave_write_enable == $past(reg_wdata[0]) && slave_read_enable == $past(reg_wdata[1]))
		else $error("slave enables do not follow config write");
	AST_SRST_WR: assert property (reg_wr && reg_addr == IEF_OFS_SOFT_RST
		|=> port_soft_reset_bit == $past(reg_wdata[0]))
		else $error("soft reset bit does not follow write");
endmodule : ief_event_status_asserts

bind ief_event_status ief_event_status_asserts u_asserts (.core_clk(core_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.slave_access_abort(slave_access_abort), .slave_write_enable(slave_write_enable),
	.slave_read_enable(slave_read_enable), .port_soft_reset_bit(port_soft_reset_bit), .irq(irq));

//--- verif/ief_engine_model.sv
// Stand-in for the serial engines: turns a fire request into one-cycle event pulses.
// Assumes requests on core_clk; delay sets how slowly the engines answer.
`timescale 1ns/1ps
module ief_engine_model (
	input  wire logic        core_clk,
	input  wire logic [10:0] fire,
	input  wire logic [3:0]  delay,
	output logic      [10:0] ev
);
	logic [10:0] pend_r = 11'h000;
	logic [3:0]  cnt_r  = 4'h0;

	initial ev = 11'h000;
	// Events are single-cycle pulses, never held levels
	// Plain always: ev also has an initial value, which always_ff forbids
	always @(posedge core_clk) begin
		ev <= 11'h000;
		if (fire != 11'h000) begin
			pend_r <= fire;
			cnt_r  <= delay;
		end else if (pend_r != 11'h000) begin
			if (cnt_r == 4'h0) begin
				ev     <= pend_r;
				pend_r <= 11'h000;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule : ief_engine_model

//--- verif/testbench.sv
// Self-checking bench for the event status flag block.
// Assumes the engine model drives all event inputs.
`timescale 1ns/1ps
module testbench import ief_pkg::*;;
	logic        core_clk  = 1'b0;
	logic        resetn    = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        bl_dis    = 1'b0;
	logic        bl_act    = 1'b0;
	logic [10:0] fire      = 11'h000;
	logic [3:0]  dly       = 4'h0;
	logic [31:0] reg_rdata;
	logic [10:0] ev;
	logic        sw_en, sr_en, srst, irq;
	int          n_mismatch = 0, n_compared = 0, cyc = 0;
	logic [31:0] exp_tab [11] = '{32'h0000_8000, 32'h0010_0000, 32'h0020_0000, 32'h0040_0000, 32'h0080_0000,
		32'h0100_0000, 32'h0800_0000, 32'h1000_0000, 32'h2000_0000, 32'h4000_0000, 32'h8000_0000};

	ief_event_status u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_load_disabled(bl_dis),
		.boot_load_active(bl_act), .boot_load_success(ev[0]), .slave_access_abort(ev[1]),
		.slave_internal_write_done(ev[2]), .slave_internal_read_done(ev[3]), .slave_access_success(ev[4]),
		.master_diagnostic_event(ev[5]), .master_arbitration_lost(ev[6]), .master_timeout_abort(ev[7]),
		.master_nack_abort(ev[8]), .master_arbitration_timeout(ev[9]), .master_transaction_success(ev[10]),
		.slave_write_enable(sw_en), .slave_read_enable(sr_en), .port_soft_reset_bit(srst), .irq(irq));
	ief_engine_model u_eng (.core_clk(core_clk), .fire(fire), .delay(dly), .ev(ev));

	initial forever #5 core_clk = ~core_clk;

	task automatic close_out;
		if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Extra idle edge after each strobe so no signal is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk(what, d, exp);
		@(posedge core_clk);
	endtask : rchk

	// Returns at the edge where the design samples the event
	task automatic go(input logic [10:0] m);
		fire <= m;
		@(posedge core_clk);
		fire <= 11'h000;
		repeat (dly + 2) @(posedge core_clk);
	endtask : go

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out();
		end
	end

	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		for (int a = 0; a < 8; a++) rchk("reset value", 8'(a * 4), 32'h0);
		wr(IEF_OFS_SLV_CFG, 32'h3);
		chk("slave enables on", {30'h0, sr_en, sw_en}, 32'h3);
		rchk("slave config", IEF_OFS_SLV_CFG, 32'h3);
		wr(IEF_OFS_ENABLE, 32'hffff_ffff);
		rchk("enable readback", IEF_OFS_ENABLE, 32'hf9f0_8000);
		for (int i = 0; i < 11; i++) begin
			go(11'h001 << i);
			rchk("event flag", IEF_OFS_STATUS, exp_tab[i]);
			chk("irq enabled", {31'h0, irq}, 32'h1);
			rchk("snapshot", IEF_OFS_SNAPSHOT, exp_tab[i]);
			wr(IEF_OFS_STATUS, ~exp_tab[i]);
			rchk("flag kept", IEF_OFS_STATUS, exp_tab[i]);
			wr(IEF_OFS_STATUS, exp_tab[i]);
			rchk("flag cleared", IEF_OFS_STATUS, 32'h0);
		end
		wr(IEF_OFS_SLV_CFG, 32'h0);
		chk("slave enables off", {30'h0, sr_en, sw_en}, 32'h0);
		go(11'h00c);
		rchk("gated slave flags", IEF_OFS_STATUS, 32'h0);
		bl_act <= 1'b1;
		go(11'h7c0);
		rchk("boot-time master flags", IEF_OFS_STATUS, 32'h3800_0000);
		bl_act <= 1'b0;
		wr(IEF_OFS_STATUS, 32'hffff_ffff);
		wr(IEF_OFS_ENABLE, 32'h0010_0000);
		dly <= 4'h5;
		go(11'h020);
		rchk("masked flag", IEF_OFS_STATUS, 32'h0100_0000);
		chk("irq masked", {31'h0, irq}, 32'h0);
		go(11'h002);
		rchk("pending", IEF_OFS_PENDING, 32'h0010_0000);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		dly <= 4'h0;
		wr(IEF_OFS_SET, 32'hffff_ffff);
		rchk("set all", IEF_OFS_STATUS, 32'hf9f0_8000);
		rchk("set reads zero", IEF_OFS_SET, 32'h0);
		wr(IEF_OFS_SOFT_RST, 32'h1);
		chk("soft reset out", {31'h0, srst}, 32'h1);
		rchk("soft reset clears", IEF_OFS_STATUS, 32'h0);
		go(11'h7ff);
		wr(IEF_OFS_SET, 32'hffff_ffff);
		rchk("events dropped", IEF_OFS_STATUS, 32'h0);
		rchk("soft reset readback", IEF_OFS_SOFT_RST, 32'h1);
		wr(IEF_OFS_SOFT_RST, 32'h0);
		chk("soft reset released", {31'h0, srst}, 32'h0);
		rchk("no flag after release", IEF_OFS_STATUS, 32'h0);
		chk("irq after release", {31'h0, irq}, 32'h0);
		go(11'h001);
		rchk("new event after release", IEF_OFS_STATUS, 32'h0000_8000);
		bl_dis <= 1'b1;
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rchk("boot load disabled", IEF_OFS_STATUS, 32'h0000_8000);
		close_out();
	end
endmodule : testbench
